/* sdp_pkg.sv */
package sdp_pkg;

	// divider field widths and serial frame length
	localparam int unsigned SDP_M_W        = 9;
	localparam int unsigned SDP_N_W        = 2;
	localparam int unsigned SDP_T_W        = 2;
	localparam int unsigned SDP_FRAME_LEN  = SDP_T_W + SDP_N_W + SDP_M_W;

	// output divider ratio is the code plus this base
	localparam logic [2:0]  SDP_OUT_RATIO_BASE = 3'h3;

	// avalon register byte addresses
	localparam int unsigned SDP_ADDR_W       = 4;
	localparam logic [3:0]  SDP_ADDR_STATUS  = 4'h0;
	localparam logic [3:0]  SDP_ADDR_CTRL    = 4'h4;

	// status register field positions
	localparam int unsigned SDP_STAT_M_LSB   = 0;
	localparam int unsigned SDP_STAT_N_LSB   = 9;
	localparam int unsigned SDP_STAT_T_LSB   = 11;
	localparam int unsigned SDP_STAT_CLR_BIT = 13;
	localparam int unsigned SDP_STAT_SER_BIT = 14;
	localparam int unsigned SDP_STAT_PLL_BIT = 15;

	// control register field positions
	localparam int unsigned SDP_CTRL_CLR_BIT = 0;

	// values after reset
	localparam logic [8:0]  SDP_M_RST        = 9'h000;
	localparam logic [1:0]  SDP_N_RST        = 2'h0;
	localparam logic [1:0]  SDP_T_RST        = 2'h0;

	// diagnostic source codes
	localparam logic [1:0]  SDP_DIAG_LOW     = 2'h0;
	localparam logic [1:0]  SDP_DIAG_SDATA   = 2'h1;
	localparam logic [1:0]  SDP_DIAG_FB      = 2'h2;
	localparam logic [1:0]  SDP_DIAG_CLK     = 2'h3;

	// loaded divider configuration; field order is also the serial frame order
	typedef struct packed {
		logic [1:0] t;
		logic [1:0] n;
		logic [8:0] m;
	} sdp_cfg_s;

	// the whole state of the block
	typedef struct packed {
		sdp_cfg_s    cfg;
		logic [12:0] shift;
		logic        sclk_prev;
		logic        sload_prev;
		logic        strobe_prev;
		logic        ref_prev;
		logic [8:0]  fb_cnt;
		logic        fb_out;
		logic [2:0]  out_cnt;
		logic        out0_true;
		logic        out0_comp;
		logic        out1_true;
		logic        out1_comp;
		logic        diag;
		logic        ref_xtal;
		logic        pll_on;
		logic        soft_clr;
		logic        wait_req;
		logic [31:0] rdata;
	} sdp_state_s;

endpackage : sdp_pkg

/* sdp_synth_div_prog.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - clear high: dividers reset, true low, comp high
// - clear low: dividers run, outputs enabled
// - clear leaves loaded divider values untouched
// - every shift clock rise shifts data in
// - reference select high picks crystal, low alternate
// - separate select picks PLL or bypass
// - nine-bit feedback, two-bit output divider pins
// - strobe low: pins pass through, diag low
// - strobe rise captures pins until next event
// - serial mode: clear low, strobe high, load low
// - load rise copies shift register to dividers
// - load fall freezes divider values
// - load held high: each shift updates dividers
// - output codes 0..3 divide by 3..6
// - feedback code is plain binary ratio
// - diag select: low, data, feedback, clock
module sdp_synth_div_prog (
	input  wire logic                                clk,
	input  wire logic                                rst,
	input  wire logic                                divider_clear,
	input  wire logic                                parallel_latch_strobe_n,
	input  wire logic [sdp_pkg::SDP_M_W-1:0]         feedback_div_bits,
	input  wire logic [sdp_pkg::SDP_N_W-1:0]         output_div_bits,
	input  wire logic                                shift_clock,
	input  wire logic                                shift_data,
	input  wire logic                                shift_load,
	input  wire logic                                ref_source_select,
	input  wire logic                                pll_bypass_select,
	input  wire logic                                xtal_ref_in,
	input  wire logic                                alt_ref_in,
	input  wire logic [sdp_pkg::SDP_ADDR_W-1:0]      avs_address,
	input  wire logic                                avs_read,
	input  wire logic                                avs_write,
	input  wire logic [31:0]                         avs_writedata,
	output var  logic [31:0]                         avs_readdata,
	output var  logic                                avs_waitrequest,
	output var  logic                                clk_out0_true,
	output var  logic                                clk_out0_comp,
	output var  logic                                clk_out1_true,
	output var  logic                                clk_out1_comp,
	output var  logic                                diag_out,
	output var  logic                                ref_is_xtal,
	output var  logic                                pll_active,
	output var  sdp_pkg::sdp_cfg_s                   div_config
);

	// output divide ratio from its two-bit code
	function automatic logic [2:0] out_ratio(input logic [1:0] code);
		out_ratio = sdp_pkg::SDP_OUT_RATIO_BASE + {1'b0, code};
	endfunction : out_ratio

	// length of the high phase for a given ratio; odd ratios run short high
	function automatic logic [8:0] high_len(input logic [8:0] ratio);
		high_len = ratio >> 1;
	endfunction : high_len

	sdp_pkg::sdp_state_s s_r;
	sdp_pkg::sdp_state_s s_nxt;

	logic        clr_eff;
	logic        sclk_rise;
	logic        sload_rise;
	logic        strobe_rise;
	logic        ref_level;
	logic        ref_rise;
	logic        advance;
	logic [12:0] shift_new;
	logic [2:0]  o_ratio;
	logic [8:0]  fb_ratio;
	logic        ser_mode;

	// pins are synchronous to clk, so edges are found against last cycle's level
	assign clr_eff     = divider_clear | s_r.soft_clr;
	assign sclk_rise   = shift_clock & ~s_r.sclk_prev;
	assign sload_rise  = shift_load & ~s_r.sload_prev;
	assign strobe_rise = parallel_latch_strobe_n & ~s_r.strobe_prev;
	assign ref_level   = ref_source_select ? xtal_ref_in : alt_ref_in;
	assign ref_rise    = ref_level & ~s_r.ref_prev;
	assign advance     = s_r.pll_on | ref_rise;
	assign shift_new   = {s_r.shift[11:0], shift_data};
	assign o_ratio     = out_ratio(s_r.cfg.n);
	assign fb_ratio    = (s_r.cfg.m == 9'h000) ? 9'h001 : s_r.cfg.m;
	assign ser_mode    = ~clr_eff & parallel_latch_strobe_n & ~shift_load;

	// next-state logic for the whole block
	always_comb begin
		s_nxt             = s_r;
		s_nxt.sclk_prev   = shift_clock;
		s_nxt.sload_prev  = shift_load;
		s_nxt.strobe_prev = parallel_latch_strobe_n;
		s_nxt.ref_prev    = ref_level;
		s_nxt.ref_xtal    = ref_source_select;
		s_nxt.pll_on      = pll_bypass_select;

		// shifting ignores mode and clear so the host can preload at any time
		if (sclk_rise) begin
			s_nxt.shift = shift_new;
		end

		// divider value loading; a held clear freezes what is loaded
		if (!clr_eff) begin
			if (!parallel_latch_strobe_n) begin
				s_nxt.cfg.m = feedback_div_bits;
				s_nxt.cfg.n = output_div_bits;
			end else if (strobe_rise && !shift_load) begin
				s_nxt.cfg.m = feedback_div_bits;
				s_nxt.cfg.n = output_div_bits;
			end else if (sload_rise && !shift_clock) begin
				s_nxt.cfg = sdp_pkg::sdp_cfg_s'(s_r.shift);
			end else if (shift_load && sclk_rise) begin
				s_nxt.cfg = sdp_pkg::sdp_cfg_s'(shift_new);
			end
			// load falling or low with the strobe settled high: nothing above fires, values stay put
		end

		// output and feedback dividers; clk stands in for the oscillator
		if (clr_eff) begin
			s_nxt.out_cnt   = 3'h0;
			s_nxt.fb_cnt    = 9'h000;
			s_nxt.fb_out    = 1'b0;
			s_nxt.out0_true = 1'b0;
			s_nxt.out0_comp = 1'b1;
			s_nxt.out1_true = 1'b0;
			s_nxt.out1_comp = 1'b1;
		end else if (advance) begin
			if (s_r.out_cnt >= o_ratio - 3'h1) begin
				s_nxt.out_cnt = 3'h0;
			end else begin
				s_nxt.out_cnt = s_r.out_cnt + 3'h1;
			end
			s_nxt.out0_true = {6'h00, s_nxt.out_cnt} < high_len({6'h00, o_ratio});
			s_nxt.out0_comp = ~s_nxt.out0_true;
			s_nxt.out1_true = s_nxt.out0_true;
			s_nxt.out1_comp = ~s_nxt.out0_true;
			// the feedback divider only exists while the loop is in use
			if (s_r.pll_on) begin
				if (s_r.fb_cnt >= fb_ratio - 9'h001) begin
					s_nxt.fb_cnt = 9'h000;
				end else begin
					s_nxt.fb_cnt = s_r.fb_cnt + 9'h001;
				end
				s_nxt.fb_out = (s_nxt.fb_cnt < high_len(fb_ratio));
			end
		end

		// diagnostic pin source, forced low while pins drive the dividers
		if (!parallel_latch_strobe_n) begin
			s_nxt.diag = 1'b0;
		end else begin
			case (s_r.cfg.t)
				sdp_pkg::SDP_DIAG_LOW:   s_nxt.diag = 1'b0;
				sdp_pkg::SDP_DIAG_SDATA: s_nxt.diag = shift_data;
				sdp_pkg::SDP_DIAG_FB:    s_nxt.diag = s_r.fb_out;
				sdp_pkg::SDP_DIAG_CLK:   s_nxt.diag = s_r.out0_true;
				default:                 s_nxt.diag = 1'b0;
			endcase
		end

		// avalon slave: one wait cycle, then the answer edge
		if (s_r.wait_req && (avs_read || avs_write)) begin
			s_nxt.wait_req = 1'b0;
			s_nxt.rdata    = 32'h0000_0000;
			if (avs_address == sdp_pkg::SDP_ADDR_STATUS) begin
				s_nxt.rdata[sdp_pkg::SDP_STAT_M_LSB +: 9] = s_r.cfg.m;
				s_nxt.rdata[sdp_pkg::SDP_STAT_N_LSB +: 2] = s_r.cfg.n;
				s_nxt.rdata[sdp_pkg::SDP_STAT_T_LSB +: 2] = s_r.cfg.t;
				s_nxt.rdata[sdp_pkg::SDP_STAT_CLR_BIT]    = clr_eff;
				s_nxt.rdata[sdp_pkg::SDP_STAT_SER_BIT]    = ser_mode;
				s_nxt.rdata[sdp_pkg::SDP_STAT_PLL_BIT]    = s_r.pll_on;
			end else if (avs_address == sdp_pkg::SDP_ADDR_CTRL) begin
				s_nxt.rdata[sdp_pkg::SDP_CTRL_CLR_BIT] = s_r.soft_clr;
			end
		end else if (!s_r.wait_req) begin
			s_nxt.wait_req = 1'b1;
			if (avs_write && avs_address == sdp_pkg::SDP_ADDR_CTRL) begin
				s_nxt.soft_clr = avs_writedata[sdp_pkg::SDP_CTRL_CLR_BIT];
			end
		end
	end

	// single state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r           <= '0;
			s_r.cfg.m     <= sdp_pkg::SDP_M_RST;
			s_r.cfg.n     <= sdp_pkg::SDP_N_RST;
			s_r.cfg.t     <= sdp_pkg::SDP_T_RST;
			s_r.out0_comp <= 1'b1;
			s_r.out1_comp <= 1'b1;
			s_r.pll_on    <= 1'b1;
			s_r.ref_xtal  <= 1'b1;
			s_r.wait_req  <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// every output is a flip-flop of the state
	assign avs_readdata    = s_r.rdata;
	assign avs_waitrequest = s_r.wait_req;
	assign clk_out0_true   = s_r.out0_true;
	assign clk_out0_comp   = s_r.out0_comp;
	assign clk_out1_true   = s_r.out1_true;
	assign clk_out1_comp   = s_r.out1_comp;
	assign diag_out        = s_r.diag;
	assign ref_is_xtal     = s_r.ref_xtal;
	assign pll_active      = s_r.pll_on;
	assign div_config      = s_r.cfg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// clear drives outputs to their reset polarity
	property p_clear_out;
		divider_clear |=> !clk_out0_true && clk_out0_comp && !clk_out1_true && clk_out1_comp;
	endproperty
	a_clear_out: assert property (p_clear_out) else $error("clear did not park outputs");

	// a running loop never leaves the true output low for six cycles
	property p_run;
		(!clr_eff && s_r.pll_on && !clk_out0_true)[*6] |-> 1'b0;
	endproperty
	a_run: assert property (p_run) else $error("outputs stalled while running");

	// clear with no load activity keeps the configuration
	property p_clear_hold;
		divider_clear && !shift_load && !s_r.sload_prev && parallel_latch_strobe_n
			|=> $stable(div_config);
	endproperty
	a_clear_hold: assert property (p_clear_hold) else $error("clear changed loaded values");

	// each shift clock rise takes one bit in
	property p_shift;
		sclk_rise |=> s_r.shift == {$past(s_r.shift[11:0]), $past(shift_data)};
	endproperty
	a_shift: assert property (p_shift) else $error("shift register missed a bit");

	// reference select level follows the pin
	property p_ref;
		##1 1'b1 |-> ref_is_xtal == $past(ref_source_select);
	endproperty
	a_ref: assert property (p_ref) else $error("reference select not followed");

	// strobe low passes pins through and silences diag
	property p_pass;
		!clr_eff && !parallel_latch_strobe_n |=> div_config.m == $past(feedback_div_bits)
			&& div_config.n == $past(output_div_bits) && !diag_out;
	endproperty
	a_pass: assert property (p_pass) else $error("parallel pass-through wrong");

	// strobe rise captures the pins and holds them while nothing else happens
	property p_capture;
		!clr_eff && strobe_rise && !shift_load ##1
			(parallel_latch_strobe_n && !shift_load && !sclk_rise && !divider_clear)[*2]
			|-> div_config.m == $past(feedback_div_bits, 2);
	endproperty
	a_capture: assert property (p_capture) else $error("parallel capture lost");

	// load rise copies the shift register
	property p_sload;
		!clr_eff && parallel_latch_strobe_n && sload_rise && !shift_clock
			|=> div_config == sdp_pkg::sdp_cfg_s'($past(s_r.shift));
	endproperty
	a_sload: assert property (p_sload) else $error("shift contents not transferred");

	// load held high follows each shifted bit
	property p_through;
		!clr_eff && parallel_latch_strobe_n && shift_load && s_r.sload_prev && sclk_rise
			|=> div_config == sdp_pkg::sdp_cfg_s'(s_r.shift);
	endproperty
	a_through: assert property (p_through) else $error("held load did not pass data");

	// output divider wraps at its coded ratio and then goes high
	property p_ndiv;
		!clr_eff && advance && !divider_clear && s_r.out_cnt == o_ratio - 3'h1
			|=> s_r.out_cnt == 3'h0 && clk_out0_true;
	endproperty
	a_ndiv: assert property (p_ndiv) else $error("output divider ratio wrong");

	// diag shows shift data when selected
	property p_diag;
		parallel_latch_strobe_n && s_r.cfg.t == sdp_pkg::SDP_DIAG_SDATA
			|=> diag_out == $past(shift_data);
	endproperty
	a_diag: assert property (p_diag) else $error("diag source wrong");

	// diag shows nothing when the low source is selected
	property p_diag_low;
		parallel_latch_strobe_n && s_r.cfg.t == sdp_pkg::SDP_DIAG_LOW |=> !diag_out;
	endproperty
	a_diag_low: assert property (p_diag_low) else $error("diag not low");

	// diag shows the feedback divider output when selected
	property p_diag_fb;
		parallel_latch_strobe_n && s_r.cfg.t == sdp_pkg::SDP_DIAG_FB |=> diag_out == $past(s_r.fb_out);
	endproperty
	a_diag_fb: assert property (p_diag_fb) else $error("diag not feedback");

	// feedback divider wraps after its binary code count; code 0 and 1 both divide by one
	property p_fbdiv;
		!clr_eff && s_r.pll_on && s_r.cfg.m > 9'h001 && s_r.fb_cnt == s_r.cfg.m - 9'h001
			|=> s_r.fb_cnt == 9'h000;
	endproperty
	a_fbdiv: assert property (p_fbdiv) else $error("feedback divider ratio wrong");

	// clear also parks the feedback divider
	property p_fb_clear;
		clr_eff |=> s_r.fb_cnt == 9'h000 && !s_r.fb_out;
	endproperty
	a_fb_clear: assert property (p_fb_clear) else $error("feedback divider not cleared");

	// both output pairs carry the same clock, comp always the inverse of true
	property p_pair;
		1'b1 |-> clk_out1_true == clk_out0_true && clk_out0_comp == !clk_out0_true
			&& clk_out1_comp == !clk_out0_true;
	endproperty
	a_pair: assert property (p_pair) else $error("output pair mismatch");

	// bypass select level follows the pin one cycle later
	property p_pll_copy;
		##1 1'b1 |-> pll_active == $past(pll_bypass_select);
	endproperty
	a_pll_copy: assert property (p_pll_copy) else $error("bypass select not followed");

	// in bypass the dividers only step on a rise of the selected reference
	property p_bypass_hold;
		!clr_eff && !s_r.pll_on && !ref_rise |=> $stable(s_r.out_cnt);
	endproperty
	a_bypass_hold: assert property (p_bypass_hold) else $error("bypass stepped without ref");

	// a selected reference rise advances the output divider by one in bypass
	property p_ref_step;
		!clr_eff && !s_r.pll_on && ref_rise && s_r.out_cnt < o_ratio - 3'h1
			|=> s_r.out_cnt == $past(s_r.out_cnt) + 3'h1;
	endproperty
	a_ref_step: assert property (p_ref_step) else $error("reference rise not counted");

	// load low with the strobe settled high freezes the loaded values
	property p_freeze;
		!clr_eff && parallel_latch_strobe_n && s_r.strobe_prev && !shift_load
			|=> $stable(div_config);
	endproperty
	a_freeze: assert property (p_freeze) else $error("values moved while latched");

endmodule : sdp_synth_div_prog

`default_nettype wire

/* sdp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// host on the serial pins; clock and load levels are held for several clk cycles, the spoiled data level for one
module sdp_host_model (
	input  wire logic clk,
	output var  logic shift_clock,
	output var  logic shift_data,
	output var  logic shift_load
);
	int unsigned slow = 0; // extra hold cycles, raised to mimic a sluggish host

	initial begin
		shift_clock = 1'b0;
		shift_data  = 1'b1;
		shift_load  = 1'b0;
	end

	// data set up while the clock rests low, then spoiled so stale bits are not trusted
	task send_bit(input logic b);
		@(posedge clk) shift_data <= b;
		repeat (2 + slow) @(posedge clk);
		shift_clock <= 1'b1;
		repeat (2 + slow) @(posedge clk);
		shift_clock <= 1'b0;
		@(posedge clk) shift_data <= ~b;
	endtask : send_bit

	// first bit out is the top of the word
	task send_frame(input logic [12:0] v);
		for (int i = 12; i >= 0; i--) send_bit(v[i]);
	endtask : send_frame

	// transfer level changes only while the shift clock is low
	task set_load(input logic v);
		repeat (2) @(posedge clk);
		shift_load <= v;
		repeat (3) @(posedge clk);
	endtask : set_load
endmodule : sdp_host_model

`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              clr = 1'b0;
	logic              stb_n = 1'b1;
	logic [8:0]        fb = 9'h000;
	logic [1:0]        od = 2'h0;
	logic              rsel = 1'b1;
	logic              psel = 1'b1;
	logic              xtal = 1'b0;
	logic              alt = 1'b0;
	logic [3:0]        adr = 4'h0;
	logic              rd_en = 1'b0;
	logic              wr_en = 1'b0;
	logic [31:0]       wd = 32'h0;
	wire logic [31:0]  rdata;
	wire logic         wreq, o0t, o0c, o1t, o1c, diag, rx, pa, sck, sd, sl;
	sdp_pkg::sdp_cfg_s cfg;
	logic [12:0]       exp_cfg = 13'h0;
	logic [12:0]       f;
	logic [31:0]       rd;
	int                miscompares = 0;
	int                cmp_count = 0;
	int                cyc = 0;
	int                p;

	sdp_host_model host (.clk(clk), .shift_clock(sck), .shift_data(sd), .shift_load(sl));
	sdp_synth_div_prog dut (.clk(clk), .rst(rst), .divider_clear(clr),
		.parallel_latch_strobe_n(stb_n), .feedback_div_bits(fb), .output_div_bits(od),
		.shift_clock(sck), .shift_data(sd), .shift_load(sl), .ref_source_select(rsel),
		.pll_bypass_select(psel), .xtal_ref_in(xtal), .alt_ref_in(alt), .avs_address(adr),
		.avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wd), .avs_readdata(rdata),
		.avs_waitrequest(wreq), .clk_out0_true(o0t), .clk_out0_comp(o0c),
		.clk_out1_true(o1t), .clk_out1_comp(o1c), .diag_out(diag), .ref_is_xtal(rx),
		.pll_active(pa), .div_config(cfg));

	always #2.5 clk = ~clk;

	// references run unrelated to each other; a hang is cut short here
	always @(posedge clk) begin
		xtal <= ($urandom_range(3) == 0) ? ~xtal : xtal;
		alt  <= ~alt;
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			wrap_up();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// one avalon transfer; request held until waitrequest is sampled low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		adr   <= a;
		wr_en <= wr;
		rd_en <= ~wr;
		wd    <= d;
		do begin
			@(posedge clk);
		end while (wreq !== 1'b0);
		rd = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask : bus

	// rise to rise period of the first true output, bounded wait
	task period(output int q);
		int n;
		n = 0;
		q = 0;
		while (o0t !== 1'b0 && n < 40) begin @(posedge clk); n++; end
		while (o0t !== 1'b1 && n < 80) begin @(posedge clk); n++; end
		while (o0t !== 1'b0 && n < 120) begin @(posedge clk); n++; q++; end
		while (o0t !== 1'b1 && n < 160) begin @(posedge clk); n++; q++; end
	endtask : period

	task wrap_up();
		$display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	initial begin
		void'($urandom(32'h88474235));
		repeat (16) @(posedge clk);
		chk(32'({o0t, o0c, o1t, o1c}), 32'h5, "reset outputs");
		rst <= 1'b0;
		// registers: status reset value, read-only, unmapped, soft clear
		bus(1'b0, sdp_pkg::SDP_ADDR_STATUS, 32'h0);
		chk(rd & 32'hbfff, 32'h8000, "status reset");
		bus(1'b1, sdp_pkg::SDP_ADDR_STATUS, 32'hffff);
		bus(1'b0, sdp_pkg::SDP_ADDR_STATUS, 32'h0);
		chk(rd & 32'hbfff, 32'h8000, "status read only");
		bus(1'b0, 4'h8, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		bus(1'b1, sdp_pkg::SDP_ADDR_CTRL, 32'h1);
		bus(1'b0, sdp_pkg::SDP_ADDR_STATUS, 32'h0);
		chk(rd & 32'hbfff, 32'ha000, "soft clear");
		chk(32'({o0t, o0c}), 32'h1, "soft clear outputs");
		bus(1'b1, sdp_pkg::SDP_ADDR_CTRL, 32'h0);
		// parallel path: pass through, capture on strobe rise, every output code
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			fb    <= 9'($urandom);
			od    <= 2'(k);
			stb_n <= 1'b0;
			repeat (4) @(posedge clk);
			exp_cfg = {exp_cfg[12:11], od, fb};
			chk(32'(cfg), 32'(exp_cfg), "pass through");
			chk(32'(diag), 32'h0, "diag low");
			period(p);
			chk(p, k + 3, "output ratio");
			chk(32'({o1t, o0c, o1c}), 32'({o0t, ~o0t, ~o0t}), "output pairs");
			stb_n <= 1'b1;
			repeat (2) @(posedge clk);
			fb <= ~fb;
			repeat (4) @(posedge clk);
			chk(32'(cfg), 32'(exp_cfg), "captured");
		end
		// serial path, a prompt host then a slow one
		for (int s = 0; s < 2; s++) begin
			host.slow = 2 * s;
			f = 13'($urandom);
			f[12:11] = 2'(s);
			host.send_frame(f);
			chk(32'(cfg), 32'(exp_cfg), "no load yet");
			host.set_load(1'b1);
			chk(32'(cfg), 32'(f), "load rise");
			host.set_load(1'b0);
			exp_cfg = f;
			chk(32'(diag), s ? 32'(sd) : 32'h0, "diag source");
			host.send_frame(~f);
			chk(32'(cfg), 32'(exp_cfg), "frozen");
		end
		// load held high: each shifted bit reaches the dividers
		host.set_load(1'b1);
		exp_cfg = ~f;
		for (int b = 0; b < 2; b++) begin
			f = {exp_cfg[11:0], 1'(b)};
			host.send_bit(1'(b));
			exp_cfg = f;
			chk(32'(cfg), 32'(exp_cfg), "live shift");
		end
		host.set_load(1'b0);
		// clear pin: outputs forced, loads refused, values kept
		@(posedge clk);
		clr   <= 1'b1;
		stb_n <= 1'b0;
		fb    <= 9'($urandom);
		repeat (4) @(posedge clk);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			chk(32'({o0t, o0c, o1t, o1c}), 32'h5, "clear outputs");
		end
		chk(32'(cfg), 32'(exp_cfg), "clear keeps");
		// strobe rises while clear still refuses loads, so nothing is captured
		stb_n <= 1'b1;
		@(posedge clk);
		clr   <= 1'b0;
		repeat (4) @(posedge clk);
		chk(32'(cfg), 32'(exp_cfg), "after clear");
		// reference and bypass selects, all four pairs
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			{rsel, psel} <= 2'(i);
			repeat (3) @(posedge clk);
			chk(32'({rx, pa}), 32'(i), "selects");
			if (i == 0) begin
				period(p);
				chk(p, 32'(2 * (int'(exp_cfg[10:9]) + 3)), "bypass ratio");
			end
		end
		wrap_up();
	end
endmodule : tb_top

`default_nettype wire
